/* core/lpc_top.sv */
// Panel port configuration and command/parameter transfer, AXI4-Lite
`timescale 1ns/1ps
module lpc_top import lpc_pkg::*; #(
  parameter int PIX_HALF = PIX_HALF_CYC,
  parameter int SER_HALF = SER_HALF_CYC,
  parameter int WR_PULSE = WR_PULSE_CYC
) (
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  input  wire logic              ce_i,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  input  wire logic [23:0]       rgb_data_i,
  input  wire logic              rgb_de_i,
  output logic                   panel_shift_clock_o,
  output logic [23:0]            panel_data_o,
  output logic                   panel_data_ready_out_o,
  output logic                   panel_chip_select_n_o,
  output logic                   cmd_param_select_out_o,
  output logic                   panel_write_strobe_o,
  output logic                   panel_serial_clock_o,
  output logic                   panel_serial_data_o
);
  // ==========================================================
  // Write channel
  logic              aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [15:0]       wdata_r, wdata_nxt;
  logic [1:0]        wstrb_r, wstrb_nxt, bresp_nxt;
  logic              awready_nxt, wready_nxt, bvalid_nxt;
  logic              aw_fire, w_fire, do_wr, wr_hit;

  assign aw_fire = s_axi_awvalid_i & s_axi_awready_o;
  assign w_fire  = s_axi_wvalid_i & s_axi_wready_o;
  assign do_wr   = aw_held_r & w_held_r & ~s_axi_bvalid_o;
  assign wr_hit  = lpc_hit(awaddr_r, IDX_IF_CFG) |
                   lpc_hit(awaddr_r, IDX_CMD) |
                   lpc_hit(awaddr_r, IDX_PARAM) |
                   lpc_hit(awaddr_r, IDX_XFER) |
                   lpc_hit(awaddr_r, IDX_LINK);

  always_comb begin
    aw_held_nxt = aw_held_r | aw_fire;
    w_held_nxt  = w_held_r | w_fire;
    awaddr_nxt  = aw_fire ? s_axi_awaddr_i : awaddr_r;
    wdata_nxt   = w_fire ? s_axi_wdata_i[15:0] : wdata_r;
    wstrb_nxt   = w_fire ? s_axi_wstrb_i[1:0] : wstrb_r;
    bvalid_nxt  = s_axi_bvalid_o & ~s_axi_bready_i;
    bresp_nxt   = s_axi_bresp_o;
    if (do_wr) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    // One write in flight: both ready drop until the response is taken
    awready_nxt = ~aw_held_nxt & ~bvalid_nxt;
    wready_nxt  = ~w_held_nxt & ~bvalid_nxt;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held_r <= 1'b0; w_held_r <= 1'b0;
      awaddr_r <= '0; wdata_r <= WORD_RST; wstrb_r <= 2'h0;
      s_axi_awready_o <= 1'b0; s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0; s_axi_bresp_o <= RESP_OKAY;
    end else if (ce_i) begin
      aw_held_r <= aw_held_nxt; w_held_r <= w_held_nxt;
      awaddr_r <= awaddr_nxt; wdata_r <= wdata_nxt; wstrb_r <= wstrb_nxt;
      s_axi_awready_o <= awready_nxt; s_axi_wready_o <= wready_nxt;
      s_axi_bvalid_o <= bvalid_nxt; s_axi_bresp_o <= bresp_nxt;
    end
  end

  // ==========================================================
  // Registers and transfer start
  logic [15:0] cfg_r, cfg_nxt, xfer_r, xfer_nxt, link_r, link_nxt;
  logic [15:0] cmd_r, cmd_nxt, par_r, par_nxt;
  logic        start_r, start_nxt, scmd_r, scmd_nxt;
  logic        tx_busy, busy_eff, wr_cmd, wr_par;

  assign busy_eff = tx_busy | start_r;
  assign wr_cmd   = do_wr & lpc_hit(awaddr_r, IDX_CMD);
  assign wr_par   = do_wr & lpc_hit(awaddr_r, IDX_PARAM);

  always_comb begin
    cfg_nxt = cfg_r; xfer_nxt = xfer_r; link_nxt = link_r;
    cmd_nxt = cmd_r; par_nxt = par_r;
    start_nxt = 1'b0; scmd_nxt = scmd_r;
    if (do_wr & lpc_hit(awaddr_r, IDX_IF_CFG))
      cfg_nxt = lpc_merge(cfg_r, wdata_r, wstrb_r, CFG_WMASK);
    if (do_wr & lpc_hit(awaddr_r, IDX_XFER))
      xfer_nxt = lpc_merge(xfer_r, wdata_r, wstrb_r, XFER_WMASK);
    if (do_wr & lpc_hit(awaddr_r, IDX_LINK))
      link_nxt = lpc_merge(link_r, wdata_r, wstrb_r, LINK_WMASK);
    // A word written while busy is dropped; the engine holds its copy
    if (wr_cmd & ~busy_eff) begin
      cmd_nxt   = lpc_merge(cmd_r, wdata_r, wstrb_r, 16'hffff);
      start_nxt = 1'b1;
      scmd_nxt  = 1'b1;
    end
    if (wr_par & ~busy_eff) begin
      par_nxt   = lpc_merge(par_r, wdata_r, wstrb_r, 16'hffff);
      start_nxt = 1'b1;
      scmd_nxt  = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_r <= CFG_RST; xfer_r <= XFER_RST; link_r <= LINK_RST;
      cmd_r <= WORD_RST; par_r <= WORD_RST;
      start_r <= 1'b0; scmd_r <= 1'b0;
    end else if (ce_i) begin
      cfg_r <= cfg_nxt; xfer_r <= xfer_nxt; link_r <= link_nxt;
      cmd_r <= cmd_nxt; par_r <= par_nxt;
      start_r <= start_nxt; scmd_r <= scmd_nxt;
    end
  end

  // ==========================================================
  // Read channel
  logic        ar_fire, arready_nxt, rvalid_nxt;
  logic [15:0] rd_val;
  logic [31:0] rdata_nxt;
  logic [1:0]  rresp_nxt, rd_resp;

  assign ar_fire = s_axi_arvalid_i & s_axi_arready_o;

  always_comb begin
    rd_val  = 16'h0000;
    rd_resp = RESP_OKAY;
    if (lpc_hit(s_axi_araddr_i, IDX_IF_CFG))      rd_val = cfg_r;
    else if (lpc_hit(s_axi_araddr_i, IDX_CMD))    rd_val = cmd_r;
    else if (lpc_hit(s_axi_araddr_i, IDX_PARAM))  rd_val = par_r;
    else if (lpc_hit(s_axi_araddr_i, IDX_STATUS))
      rd_val[STAT_BUSY] = busy_eff;
    else if (lpc_hit(s_axi_araddr_i, IDX_XFER))   rd_val = xfer_r;
    else if (lpc_hit(s_axi_araddr_i, IDX_LINK))   rd_val = link_r;
    else rd_resp = RESP_SLVERR;
    rvalid_nxt = s_axi_rvalid_o & ~s_axi_rready_i;
    rdata_nxt  = s_axi_rdata_o;
    rresp_nxt  = s_axi_rresp_o;
    if (ar_fire) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = {16'h0000, rd_val};
      rresp_nxt  = rd_resp;
    end
    arready_nxt = ~rvalid_nxt;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_arready_o <= 1'b0; s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000; s_axi_rresp_o <= RESP_OKAY;
    end else if (ce_i) begin
      s_axi_arready_o <= arready_nxt; s_axi_rvalid_o <= rvalid_nxt;
      s_axi_rdata_o <= rdata_nxt; s_axi_rresp_o <= rresp_nxt;
    end
  end

  // ==========================================================
  // Engines
  logic        rgb_en, par_en, tx_cs, tx_a0, tx_wr, tx_sclk, tx_sdo;
  logic        rgb_sh, rgb_dr;
  logic [15:0] tx_dat;
  logic [23:0] rgb_dat;
  logic [2:0]  stype;

  assign rgb_en = cfg_r[CFG_TYPE_LO +: 2] == TYPE_RGB;
  assign par_en = cfg_r[CFG_TYPE_LO +: 2] == TYPE_PAR;
  assign stype  = link_r[LINK_STYPE_LO +: 3];

  lpc_txeng #(.WR_CYC(WR_PULSE), .HALF_CYC(SER_HALF)) u_tx (
    .mclk_i       (mclk_i),
    .rst_n_i      (rst_n_i),
    .ce_i         (ce_i),
    .start_i      (start_r),
    .is_cmd_i     (scmd_r),
    .word_i       (scmd_r ? cmd_r : par_r),
    .pc_inv_i     (xfer_r[XFER_PCINV]),
    .cs_pol_i     (cfg_r[CFG_CSPOL]),
    .par8_i       (link_r[LINK_PAR8]),
    .serial_i     (stype != STYPE_NONE),
    .three_wire_i (stype[2:1] == STYPE_3W_HI),
    .busy_o       (tx_busy),
    .cs_o         (tx_cs),
    .a0_o         (tx_a0),
    .wr_o         (tx_wr),
    .data_o       (tx_dat),
    .sclk_o       (tx_sclk),
    .sdo_o        (tx_sdo)
  );

  lpc_rgbpath #(.HALF_CYC(PIX_HALF)) u_rgb (
    .mclk_i   (mclk_i),
    .rst_n_i  (rst_n_i),
    .ce_i     (ce_i),
    .en_i     (rgb_en),
    .width_i  (cfg_r[CFG_WID_LO +: 3]),
    .shpol_i  (cfg_r[CFG_SHPOL]),
    .drpol_i  (cfg_r[CFG_DRPOL]),
    .rgb_i    (rgb_data_i),
    .de_i     (rgb_de_i),
    .shift_o  (rgb_sh),
    .data_o   (rgb_dat),
    .dready_o (rgb_dr)
  );

  // ==========================================================
  // Pin registers; shift clock and data pass one stage together
  logic [23:0] pdat_nxt;

  always_comb begin
    pdat_nxt = 24'h000000;
    if (rgb_en)      pdat_nxt = rgb_dat;
    else if (par_en) pdat_nxt = {8'h00, tx_dat};
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      panel_shift_clock_o <= 1'b0; panel_data_o <= 24'h000000;
      panel_data_ready_out_o <= 1'b0; panel_chip_select_n_o <= 1'b1;
      cmd_param_select_out_o <= 1'b0; panel_write_strobe_o <= 1'b0;
      panel_serial_clock_o <= 1'b0; panel_serial_data_o <= 1'b0;
    end else if (ce_i) begin
      panel_shift_clock_o <= rgb_sh; panel_data_o <= pdat_nxt;
      panel_data_ready_out_o <= rgb_dr; panel_chip_select_n_o <= tx_cs;
      cmd_param_select_out_o <= tx_a0; panel_write_strobe_o <= tx_wr;
      panel_serial_clock_o <= tx_sclk; panel_serial_data_o <= tx_sdo;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  busy_on_start_a: assert property (
    start_r && ce_i |=> tx_busy && busy_eff)
    else $error("busy not raised at transfer start");

  cmd_level_a: assert property (
    start_r && scmd_r && ce_i |=> tx_a0 == $past(xfer_r[XFER_PCINV]))
    else $error("command level wrong on select line");

  param_level_a: assert property (
    start_r && !scmd_r && ce_i |=> tx_a0 != $past(xfer_r[XFER_PCINV]))
    else $error("parameter level wrong on select line");

  cmd_start_a: assert property (
    wr_cmd && !busy_eff && ce_i |=> start_r && scmd_r)
    else $error("idle command write did not start");

  param_start_a: assert property (
    wr_par && !busy_eff && ce_i |=> start_r && !scmd_r)
    else $error("idle parameter write did not start");

  status_read_a: assert property (
    ar_fire && ce_i && lpc_hit(s_axi_araddr_i, IDX_STATUS)
    |=> s_axi_rvalid_o && s_axi_rdata_o[0] == $past(busy_eff))
    else $error("status read does not match busy");

  narrow_width_a: assert property (
    cfg_r[CFG_WID_LO +: 3] == 3'h0 && $stable(cfg_r) && rgb_en
    |-> rgb_dat[23:9] == 15'h0000)
    else $error("9-bit mode drives upper pins");

  unused_pins_a: assert property (
    rgb_en && $stable(cfg_r)
    |-> (rgb_dat & ~lpc_width_mask(cfg_r[CFG_WID_LO +: 3])) == 24'h0)
    else $error("pins beyond width not low");

  byte_only_a: assert property (
    tx_busy && !tx_sclk && $stable(link_r) && link_r[LINK_PAR8]
    && stype == STYPE_NONE |-> tx_dat[15:8] == 8'h00)
    else $error("8-bit parallel drives upper byte");

  launch_edge_a: assert property (
    rgb_en && $stable(cfg_r) && $changed(rgb_dat)
    |-> rgb_sh == ~cfg_r[CFG_SHPOL] && $changed(rgb_sh))
    else $error("RGB data launched on wrong edge");

  reserved_type_a: assert property (
    (!rgb_en && !par_en) [*3] |-> !panel_shift_clock_o
    && panel_data_o == 24'h0)
    else $error("reserved type drives panel pins");

  cs_idle_a: assert property (
    (!busy_eff && ce_i && $stable(cfg_r)) [*2]
    |-> tx_cs == ~cfg_r[CFG_CSPOL])
    else $error("chip select active while idle");

  sclk_idle_a: assert property (
    !tx_busy |-> !tx_sclk)
    else $error("serial clock moves while idle");

  par_pins_a: assert property (
    par_en && ce_i |=> panel_data_o == {8'h00, $past(tx_dat)})
    else $error("parallel word not on panel pins");

  pin_select_a: assert property (
    ce_i |=> cmd_param_select_out_o == $past(tx_a0)
    && panel_chip_select_n_o == $past(tx_cs))
    else $error("select or chip select pin out of step");

  cmd_xfer_c:   cover property (start_r && scmd_r ##1 tx_busy);
  param_xfer_c: cover property (start_r && !scmd_r ##1 tx_busy);
  ser_xfer_c:   cover property (tx_busy && tx_sclk);
  rgb_run_c:    cover property (rgb_en && $rose(rgb_sh));
  fall_edge_c:  cover property (rgb_en && cfg_r[CFG_SHPOL] && $fell(rgb_sh));
endmodule

/* core/lpc_pkg.sv */
// Constants, types and decoders shared by the panel command port
package lpc_pkg;
  // ==========================================================
  // Register map: indices, byte address is index times four
  localparam int          ADDR_W     = 10;
  localparam logic [7:0]  IDX_IF_CFG = 8'h32;
  localparam logic [7:0]  IDX_CMD    = 8'h34;
  localparam logic [7:0]  IDX_PARAM  = 8'h36;
  localparam logic [7:0]  IDX_STATUS = 8'h38;
  localparam logic [7:0]  IDX_XFER   = 8'h3c;
  localparam logic [7:0]  IDX_LINK   = 8'h54;
  // ==========================================================
  // Field positions, write masks and reset values
  localparam int          CFG_TYPE_LO   = 0;
  localparam int          CFG_WID_LO    = 4;
  localparam int          CFG_SHPOL     = 7;
  localparam int          CFG_CSPOL     = 8;
  localparam int          CFG_DRPOL     = 9;
  localparam int          XFER_PCINV    = 7;
  localparam int          LINK_PAR8     = 0;
  localparam int          LINK_STYPE_LO = 5;
  localparam int          STAT_BUSY     = 0;
  localparam logic [15:0] CFG_WMASK     = 16'h03f3;
  localparam logic [15:0] XFER_WMASK    = 16'h0080;
  localparam logic [15:0] LINK_WMASK    = 16'h00e1;
  localparam logic [15:0] CFG_RST       = 16'h0000;
  localparam logic [15:0] XFER_RST      = 16'h0000;
  localparam logic [15:0] LINK_RST      = 16'h0000;
  localparam logic [15:0] WORD_RST      = 16'h0000;
  // ==========================================================
  // Encodings
  localparam logic [1:0]  TYPE_RGB    = 2'h0;
  localparam logic [1:0]  TYPE_PAR    = 2'h2;
  localparam logic [2:0]  STYPE_NONE  = 3'h0;
  localparam logic [1:0]  STYPE_3W_HI = 2'h2;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [4:0]  SER_BITS_8  = 5'h08;
  localparam logic [4:0]  SER_BITS_16 = 5'h10;
  // ==========================================================
  // Timing, least times rounded up to whole cycles
  localparam int CLK_NS       = 8;
  localparam int WR_PULSE_NS  = 40;
  localparam int WR_PULSE_CYC = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SER_HALF_NS  = 40;
  localparam int SER_HALF_CYC = (SER_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int PIX_HALF_CYC = 2;

  typedef enum logic [1:0] {TX_IDLE, TX_PAR, TX_SLO, TX_SHI} lpc_tx_st_t;

  function automatic logic [23:0] lpc_width_mask(input logic [2:0] code);
    unique case (code)
      3'h0:    return 24'h0001ff;
      3'h1:    return 24'h000fff;
      3'h2:    return 24'h00ffff;
      3'h3:    return 24'h03ffff;
      3'h4:    return 24'hffffff;
      default: return 24'h000000;
    endcase
  endfunction

  function automatic logic lpc_hit(input logic [ADDR_W-1:0] a,
                                   input logic [7:0]        idx);
    return a[ADDR_W-1:2] == idx;
  endfunction

  function automatic logic [15:0] lpc_merge(input logic [15:0] old,
                                            input logic [15:0] nw,
                                            input logic [1:0]  strb,
                                            input logic [15:0] wmask);
    logic [15:0] m;
    m = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
    return (old & ~m) | (nw & m);
  endfunction
endpackage

/* core/lpc_txeng.sv */
// Command and parameter word transfer engine, parallel or serial
`timescale 1ns/1ps
module lpc_txeng import lpc_pkg::*; #(
  parameter int WR_CYC   = WR_PULSE_CYC,
  parameter int HALF_CYC = SER_HALF_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        start_i,
  input  wire logic        is_cmd_i,
  input  wire logic [15:0] word_i,
  input  wire logic        pc_inv_i,
  input  wire logic        cs_pol_i,
  input  wire logic        par8_i,
  input  wire logic        serial_i,
  input  wire logic        three_wire_i,
  output logic             busy_o,
  output logic             cs_o,
  output logic             a0_o,
  output logic             wr_o,
  output logic [15:0]      data_o,
  output logic             sclk_o,
  output logic             sdo_o
);
  // ==========================================================
  // Sequencer
  lpc_tx_st_t  st_r, st_nxt;
  logic [7:0]  cnt_r, cnt_nxt;
  logic [4:0]  bits_r, bits_nxt;
  logic [15:0] sh_r, sh_nxt, dat_nxt, ld;
  logic        busy_nxt, cs_nxt, a0_nxt, wr_nxt, sclk_nxt, sdo_nxt;

  always_comb begin
    st_nxt = st_r; cnt_nxt = cnt_r; bits_nxt = bits_r; sh_nxt = sh_r;
    busy_nxt = busy_o; cs_nxt = cs_o; a0_nxt = a0_o; wr_nxt = wr_o;
    dat_nxt = data_o; sclk_nxt = sclk_o; sdo_nxt = sdo_o;
    // Three-wire keeps the upper byte as address bits ahead of data
    ld = three_wire_i ? word_i : {word_i[7:0], 8'h00};
    unique case (st_r)
      TX_IDLE: begin
        cs_nxt = ~cs_pol_i;
        if (start_i) begin
          busy_nxt = 1'b1;
          cs_nxt   = cs_pol_i;
          a0_nxt   = is_cmd_i ? pc_inv_i : ~pc_inv_i;
          cnt_nxt  = 8'h00;
          if (serial_i) begin
            st_nxt   = TX_SLO;
            bits_nxt = three_wire_i ? SER_BITS_16 : SER_BITS_8;
            sh_nxt   = ld;
            sdo_nxt  = ld[15];
            sclk_nxt = 1'b0;
          end else begin
            st_nxt  = TX_PAR;
            dat_nxt = par8_i ? {8'h00, word_i[7:0]} : word_i;
            wr_nxt  = 1'b1;
          end
        end
      end
      TX_PAR: begin
        if (cnt_r == 8'(WR_CYC - 1)) begin
          wr_nxt = 1'b0; busy_nxt = 1'b0; cs_nxt = ~cs_pol_i;
          st_nxt = TX_IDLE;
        end else cnt_nxt = cnt_r + 8'h01;
      end
      TX_SLO: begin
        if (cnt_r == 8'(HALF_CYC - 1)) begin
          sclk_nxt = 1'b1; cnt_nxt = 8'h00; st_nxt = TX_SHI;
        end else cnt_nxt = cnt_r + 8'h01;
      end
      TX_SHI: begin
        if (cnt_r == 8'(HALF_CYC - 1)) begin
          sclk_nxt = 1'b0; cnt_nxt = 8'h00; bits_nxt = bits_r - 5'h01;
          if (bits_r == 5'h01) begin
            // Busy drops only after the last bit's high phase
            busy_nxt = 1'b0; cs_nxt = ~cs_pol_i; st_nxt = TX_IDLE;
          end else begin
            sh_nxt = {sh_r[14:0], 1'b0}; sdo_nxt = sh_r[14]; st_nxt = TX_SLO;
          end
        end else cnt_nxt = cnt_r + 8'h01;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= TX_IDLE; cnt_r <= 8'h00; bits_r <= 5'h00; sh_r <= WORD_RST;
      busy_o <= 1'b0; cs_o <= 1'b1; a0_o <= 1'b0; wr_o <= 1'b0;
      data_o <= WORD_RST; sclk_o <= 1'b0; sdo_o <= 1'b0;
    end else if (ce_i) begin
      st_r <= st_nxt; cnt_r <= cnt_nxt; bits_r <= bits_nxt; sh_r <= sh_nxt;
      busy_o <= busy_nxt; cs_o <= cs_nxt; a0_o <= a0_nxt; wr_o <= wr_nxt;
      data_o <= dat_nxt; sclk_o <= sclk_nxt; sdo_o <= sdo_nxt;
    end
  end
endmodule

/* core/lpc_rgbpath.sv */
// RGB shift clock and masked pixel data launch
`timescale 1ns/1ps
module lpc_rgbpath import lpc_pkg::*; #(
  parameter int HALF_CYC = PIX_HALF_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        en_i,
  input  wire logic [2:0]  width_i,
  input  wire logic        shpol_i,
  input  wire logic        drpol_i,
  input  wire logic [23:0] rgb_i,
  input  wire logic        de_i,
  output logic             shift_o,
  output logic [23:0]      data_o,
  output logic             dready_o
);
  // ==========================================================
  // Divider and launch edge
  logic [7:0]  cnt_r, cnt_nxt;
  logic        sh_nxt, dr_nxt;
  logic [23:0] dat_nxt;

  always_comb begin
    cnt_nxt = cnt_r; sh_nxt = shift_o; dat_nxt = data_o; dr_nxt = dready_o;
    if (!en_i) begin
      cnt_nxt = 8'h00; sh_nxt = 1'b0; dat_nxt = 24'h000000; dr_nxt = drpol_i;
    end else if (cnt_r == 8'(HALF_CYC - 1)) begin
      cnt_nxt = 8'h00;
      sh_nxt  = ~shift_o;
      // Launch on rising edge when polarity clear, falling when set
      if (~shift_o == ~shpol_i) begin
        dat_nxt = rgb_i & lpc_width_mask(width_i);
        dr_nxt  = de_i ^ drpol_i;
      end
    end else cnt_nxt = cnt_r + 8'h01;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 8'h00; shift_o <= 1'b0; data_o <= 24'h000000; dready_o <= 1'b0;
    end else if (ce_i) begin
      cnt_r <= cnt_nxt; shift_o <= sh_nxt; data_o <= dat_nxt;
      dready_o <= dr_nxt;
    end
  end
endmodule

/* sim/lpc_panel_model.sv */
// Panel module model capturing parallel and serial words
`timescale 1ns/1ps
module lpc_panel_model (
  input  wire logic        strobe_i,
  input  wire logic        cs_n_i,
  input  wire logic        a0_i,
  input  wire logic [23:0] data_i,
  input  wire logic        sclk_i,
  input  wire logic        sdo_i,
  output logic [15:0]      word_o,
  output logic             a0_o,
  output logic             cs_o,
  output logic [15:0]      ser_o
);
  // ==========================================================
  // Capture just after strobe rise; pins launch on that same edge
  always @(posedge strobe_i) begin
    #1;
    word_o = data_i[15:0];
    a0_o = a0_i;
    cs_o = cs_n_i;
  end
  // Serial bits arrive MSB first, sampled on clock rise
  always @(posedge sclk_i) begin
    ser_o = {ser_o[14:0], sdo_i};
  end
endmodule

/* sim/lcd_panel_if_config_cmd_tb.sv */
// Testbench for the panel command port over AXI4-Lite
`timescale 1ns/1ps
module lcd_panel_if_config_cmd_tb;
  import lpc_pkg::*;
  localparam logic [9:0] A_CFG = {IDX_IF_CFG, 2'b00};
  localparam logic [9:0] A_CMD = {IDX_CMD, 2'b00};
  localparam logic [9:0] A_PAR = {IDX_PARAM, 2'b00};
  localparam logic [9:0] A_ST  = {IDX_STATUS, 2'b00};
  localparam logic [9:0] A_XF  = {IDX_XFER, 2'b00};
  localparam logic [9:0] A_LNK = {IDX_LINK, 2'b00};
  logic mclk_i = 0, rst_n = 0, awv = 0, wv = 0, bready = 0, arv = 0;
  logic rready = 0, de = 0, awr, wr_r, bv, arr, rv, shclk, a0, ws, sck;
  logic sd, dr, csn;
  logic [9:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [23:0] rgb = 0, pdata, v;
  logic [15:0] pw, pser;
  logic [1:0]  resp, br, rr;
  logic pa0, pcs;
  int errors = 0, n_compared = 0;
  logic [23:0] wid [5] = '{24'h1ff, 24'hfff, 24'hffff, 24'h3ffff, 24'hffffff};
  always #4 mclk_i = ~mclk_i;
  lpc_top uut (.mclk_i(mclk_i), .rst_n_i(rst_n), .ce_i(1'b1),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wr_r), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rready),
    .rgb_data_i(rgb), .rgb_de_i(de), .panel_shift_clock_o(shclk),
    .panel_data_o(pdata), .panel_data_ready_out_o(dr),
    .panel_chip_select_n_o(csn), .cmd_param_select_out_o(a0),
    .panel_write_strobe_o(ws), .panel_serial_clock_o(sck),
    .panel_serial_data_o(sd));
  lpc_panel_model u_panel (.strobe_i(ws), .cs_n_i(csn), .a0_i(a0),
    .data_i(pdata), .sclk_i(sck), .sdo_i(sd), .word_o(pw), .a0_o(pa0),
    .cs_o(pcs), .ser_o(pser));
  // ==========================================================
  // Bus tasks; outputs are flops, so pre-edge values are sampled
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    awaddr <= a;
    wdata <= {16'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_r) wv <= 1'b0;
    end while (!bv);
    resp = br;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, output logic [23:0] d);
    @(posedge mclk_i);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (arv && arr) arv <= 1'b0;
    end while (!rv);
    d = {8'h00, rdata[15:0]};
    resp = rr;
    rready <= 1'b0;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Host polls status until busy clears after every command or parameter word
  task automatic idle;
    logic [23:0] s;
    s = 24'h1;
    while (s !== 24'h0) rd(A_ST, s);
  endtask
  task automatic test_done;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========================================================
  // Sequence; clock divider never touched, so no odd ratio
  initial begin
    repeat (10) @(posedge mclk_i);
    rst_n <= 1'b1;
    rd(A_CFG, v);
    chk(v, 24'h0);
    wr(A_CFG, 16'hffff);
    rd(A_CFG, v);
    chk(v, 24'h3f3);
    wr(A_ST, 16'h0001);
    chk({22'h0, resp}, {22'h0, RESP_SLVERR});
    wr(A_CFG, 16'h0102);
    wr(A_CMD, 16'ha55a);
    rd(A_ST, v);
    chk(v, 24'h1);
    chk({22'h0, resp}, {22'h0, RESP_OKAY});
    idle();
    chk({6'h0, pcs, pa0, pw}, 24'h02a55a);
    chk({23'h0, csn}, 24'h0);
    rd(A_CMD, v);
    chk(v, 24'ha55a);
    wr(A_XF, 16'h0080);
    wr(A_PAR, 16'h0077);
    idle();
    chk({7'h0, pa0, pw}, 24'h000077);
    wr(A_CMD, 16'h0011);
    idle();
    chk({23'h0, pa0}, 24'h1);
    wr(A_LNK, 16'h0080);
    wr(A_CMD, 16'hc3a5);
    idle();
    chk({8'h0, pser}, 24'hc3a5);
    wr(A_LNK, 16'h0001);
    wr(A_PAR, 16'hbeef);
    idle();
    chk({8'h0, pw}, 24'h00ef);
    rgb <= 24'hffffff;
    de <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      wr(A_CFG, 16'(i << 4));
      repeat (20) @(posedge mclk_i);
      chk(pdata, wid[i]);
      chk({23'h0, dr}, 24'h1);
    end
    // New pixel must wait for the launch edge of the shift clock
    @(posedge shclk);
    rgb <= 24'h123456;
    @(negedge shclk);
    #1;
    chk(pdata, 24'hffffff);
    @(posedge shclk);
    #1;
    chk(pdata, 24'h123456);
    wr(A_CFG, 16'h00c0);
    @(negedge shclk);
    rgb <= 24'h654321;
    @(posedge shclk);
    #1;
    chk(pdata, 24'h123456);
    @(negedge shclk);
    #1;
    chk(pdata, 24'h654321);
    test_done();
  end
  initial begin
    #200000;
    errors++;
    test_done();
  end
endmodule
